/* File: hw/usd_link.sv */
// usb link logic: speed detection, pull-up connect, receive path, endpoint buffer, lock
// What this block does
// - after attach, stay full speed until a host bus reset is seen
// - during bus reset chirp; host handshake answer moves device to high speed
// - high speed with 3 ms bus silence falls back to full speed, checks SE0
// - SE0 held 100 to 875 us after fallback restarts the chirp handshake
// - no qualifying SE0 after fallback means full speed and suspend behaviour
// - pull-up pin connected only while connect enable bit is set
// - hardware reset clears connect enable, pull-up starts disconnected
// - usb bus reset leaves connect enable untouched
// - received data stays buffered until cpu read or dma drain releases it
// - buffer clear command discards the out buffer at once
// - hardware recognises sync, deserialises and strips stuffed bits itself
// - nrzi decode and unstuffing feed 16-bit parallel words
// - after resume, register writes blocked until unlock code is written
// - device can start a session request asking for bus power
`timescale 1ns/10ps
`default_nettype none
module usd_link
   import usd_pkg::*;
#(
   parameter int          IDLE_CYC    = IDLE_CYC_DEF,
   parameter int          SE0_MAX_CYC = SE0_MAX_CYC_DEF,
   parameter int          CHIRP_CYC   = CHIRP_CYC_DEF,
   parameter int          SRP_CYC     = SRP_CYC_DEF,
   parameter logic [1:0]  UNLOCK_SEL  = UNLOCK_SEL_DEF,
   parameter logic [15:0] UNLOCK_CODE = UNLOCK_CODE_DEF
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              bus_se0_pin,
   input  wire logic              bus_activity_pin,
   input  wire logic              host_chirp_ack_pin,
   input  wire logic              rx_line_pin,
   input  wire logic              rx_bit_stb_pin,
   input  wire logic              vbus_present_pin,
   input  wire logic              fw_wr,
   input  wire logic [1:0]        fw_sel,
   input  wire logic [15:0]       fw_wdata,
   input  wire logic              ep_read_done,
   input  wire logic              dma_drain_done,
   input  wire logic              rd_en,
   input  wire logic [AW-1:0]     rd_addr,
   output logic                   hs_mode,
   output logic                   chirp_drive,
   output logic                   suspend,
   output logic                   writes_locked,
   output logic                   pullup_resistor_pin_oe,
   output logic                   srp_drive,
   output logic                   buf_full,
   output logic [AW:0]            buf_words,
   output logic [WORD_W-1:0]      rd_data,
   output logic                   rx_overrun
);
   logic [1:0]           rsync_reg;
   logic                 rst_int_n;
   logic [PIN_COUNT-1:0] pin_s1_reg, pin_s2_reg;
   logic                 se0, act, ack, line_s, stb, vbus;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsync_reg <= 2'h0;
      end else begin
         rsync_reg <= {rsync_reg[0], 1'b1};
      end
   end
   assign rst_int_n = rsync_reg[1];

   // pins come from the analog side, so all of them pass two flops
   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         pin_s1_reg <= {vbus_present_pin, rx_bit_stb_pin, rx_line_pin,
                        host_chirp_ack_pin, bus_activity_pin, bus_se0_pin};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   assign se0    = pin_s2_reg[PIN_SE0];
   assign act    = pin_s2_reg[PIN_ACT];
   assign ack    = pin_s2_reg[PIN_ACK];
   assign line_s = pin_s2_reg[PIN_LINE];
   assign stb    = pin_s2_reg[PIN_STB];
   assign vbus   = pin_s2_reg[PIN_VBUS];

   // link state group
   usd_state_t       state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next, srp_cnt_reg, srp_cnt_next;
   logic [RUN_W-1:0] se0_run_reg, se0_run_next;
   logic             hs_reg, hs_next, chirp_reg, chirp_next, susp_reg, susp_next;
   logic             lock_reg, lock_next, conn_reg, conn_next, srp_reg, srp_next;
   logic             reset_seen, wr_ok, clr;

   assign reset_seen = (se0_run_reg == RUN_W'(SE0_MIN_CYC));
   assign wr_ok      = fw_wr && !lock_reg;
   assign clr        = wr_ok && (fw_sel == SEL_CLEAR) && fw_wdata[CLEAR_BIT];

   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg + CNT_W'(1);
      se0_run_next = se0 ? (reset_seen ? se0_run_reg : se0_run_reg + RUN_W'(1)) : '0;
      lock_next    = lock_reg;
      conn_next    = conn_reg;
      srp_next     = srp_reg;
      srp_cnt_next = srp_cnt_reg;
      unique case (state_reg)
         ST_FS: begin
            if (act || se0) cnt_next = '0;
            if (reset_seen) begin
               state_next = ST_CHIRP;
               cnt_next   = '0;
            end else if (cnt_reg == CNT_W'(IDLE_CYC - 1)) begin
               state_next = ST_SUSPEND;
            end
         end
         ST_CHIRP: begin
            if (ack) begin
               state_next = ST_HS;
               cnt_next   = '0;
            end else if (cnt_reg == CNT_W'(CHIRP_CYC - 1)) begin
               state_next = ST_FS;
               cnt_next   = '0;
            end
         end
         ST_HS: begin
            if (act) begin
               cnt_next = '0;
            end else if (cnt_reg == CNT_W'(IDLE_CYC - 1)) begin
               state_next = ST_SE0_CHK;
               cnt_next   = '0;
            end
         end
         ST_SE0_CHK: begin
            // se0 run counter runs in every state, so se0 begun before the window also counts toward the minimum
            if (reset_seen) begin
               state_next = ST_CHIRP;
               cnt_next   = '0;
            end else if (cnt_reg == CNT_W'(SE0_MAX_CYC - 1)) begin
               state_next = ST_SUSPEND;
               cnt_next   = '0;
            end
         end
         ST_SUSPEND: begin
            cnt_next = '0;
            if (act || reset_seen) begin
               state_next = ST_FS;
            end
         end
      endcase
      // unlock first, so a resume in the same cycle still locks
      if (fw_wr && fw_sel == UNLOCK_SEL && fw_wdata == UNLOCK_CODE) begin
         lock_next = 1'b0;
      end
      if (state_reg == ST_SUSPEND && state_next == ST_FS) begin
         lock_next = 1'b1;
      end
      // bus reset never touches the connect bit; only firmware does
      if (wr_ok && fw_sel == SEL_CONNECT) begin
         conn_next = fw_wdata[CONNECT_BIT];
      end
      if (srp_reg) begin
         srp_cnt_next = srp_cnt_reg + CNT_W'(1);
         if (vbus || srp_cnt_reg == CNT_W'(SRP_CYC - 1)) begin
            srp_next = 1'b0;
         end
      end else if (wr_ok && fw_sel == SEL_SRP && fw_wdata[SRP_BIT] && !vbus) begin
         srp_next     = 1'b1;
         srp_cnt_next = '0;
      end
      hs_next    = (state_next == ST_HS);
      chirp_next = (state_next == ST_CHIRP);
      susp_next  = (state_next == ST_SUSPEND);
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         state_reg   <= ST_FS;
         cnt_reg     <= '0;
         se0_run_reg <= '0;
         hs_reg      <= 1'b0;
         chirp_reg   <= 1'b0;
         susp_reg    <= 1'b0;
         lock_reg    <= 1'b0;
         conn_reg    <= 1'b0;
         srp_reg     <= 1'b0;
         srp_cnt_reg <= '0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         se0_run_reg <= se0_run_next;
         hs_reg      <= hs_next;
         chirp_reg   <= chirp_next;
         susp_reg    <= susp_next;
         lock_reg    <= lock_next;
         conn_reg    <= conn_next;
         srp_reg     <= srp_next;
         srp_cnt_reg <= srp_cnt_next;
      end
   end

   // receive group: nrzi decode, sync hunt, unstuffing, 16-bit assembly
   logic [7:0]        sync_reg, sync_next;
   logic [2:0]        ones_reg, ones_next;
   logic [3:0]        bit_reg, bit_next;
   logic [WORD_W-1:0] sh_reg, sh_next, word_reg, word_next;
   logic              prev_reg, prev_next, pkt_reg, pkt_next;
   logic              wv_reg, wv_next, ovr_reg, ovr_next, dbit;

   usd_stream_if #(.W(WORD_W)) rx_s ();
   usd_stream_if #(.W(WORD_W)) buf_s ();

   assign dbit       = (line_s == prev_reg);
   assign rx_s.data  = word_reg;
   assign rx_s.valid = wv_reg;

   always_comb begin
      sync_next = sync_reg;
      ones_next = ones_reg;
      bit_next  = bit_reg;
      sh_next   = sh_reg;
      word_next = word_reg;
      prev_next = prev_reg;
      pkt_next  = pkt_reg;
      ovr_next  = ovr_reg;
      wv_next   = wv_reg && !rx_s.ready;
      if (se0) begin
         // end of packet drops any partial word
         pkt_next  = 1'b0;
         bit_next  = '0;
         ones_next = '0;
         sync_next = '0;
      end else if (stb) begin
         prev_next = line_s;
         if (!pkt_reg) begin
            sync_next = {dbit, sync_reg[7:1]};
            if ({dbit, sync_reg[7:1]} == SYNC_MATCH) begin
               pkt_next  = 1'b1;
               ones_next = '0;
            end
         end else if (ones_reg == STUFF_RUN) begin
            ones_next = '0;
         end else begin
            ones_next = dbit ? ones_reg + 3'h1 : 3'h0;
            sh_next   = {dbit, sh_reg[WORD_W-1:1]};
            bit_next  = bit_reg + 4'h1;
            if (bit_reg == LAST_BIT) begin
               // serial side cannot wait; a word that lands while the last is still held is lost
               if (wv_reg && !rx_s.ready) begin
                  ovr_next = 1'b1;
               end else begin
                  word_next = {dbit, sh_reg[WORD_W-1:1]};
                  wv_next   = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sync_reg <= '0;
         ones_reg <= '0;
         bit_reg  <= '0;
         sh_reg   <= '0;
         word_reg <= '0;
         prev_reg <= 1'b0;
         pkt_reg  <= 1'b0;
         wv_reg   <= 1'b0;
         ovr_reg  <= 1'b0;
      end else begin
         sync_reg <= sync_next;
         ones_reg <= ones_next;
         bit_reg  <= bit_next;
         sh_reg   <= sh_next;
         word_reg <= word_next;
         prev_reg <= prev_next;
         pkt_reg  <= pkt_next;
         wv_reg   <= wv_next;
         ovr_reg  <= ovr_next;
      end
   end

   usd_skid #(.W(WORD_W)) u_skid (
      .clk   (clk),
      .rst_n (rst_int_n),
      .in_s  (rx_s),
      .out_s (buf_s)
   );

   // buffer group: one out endpoint, filled until released or cleared
   logic [AW:0]   ptr_reg, ptr_next;
   logic [AW-1:0] waddr;
   logic          push, release_buf;

   assign release_buf = ep_read_done || dma_drain_done || clr;
   assign buf_s.ready = !ptr_reg[AW];
   assign push        = buf_s.valid && buf_s.ready;
   assign waddr       = release_buf ? '0 : ptr_reg[AW-1:0];

   always_comb begin
      ptr_next = ptr_reg;
      if (release_buf) begin
         ptr_next = push ? (AW+1)'(1) : '0;
      end else if (push) begin
         ptr_next = ptr_reg + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ptr_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   usd_ram #(.W(WORD_W), .DEPTH(RAM_DEPTH), .A(AW)) u_ram (
      .clk   (clk),
      .rst_n (rst_int_n),
      .we    (push),
      .waddr (waddr),
      .wdata (buf_s.data),
      .re    (rd_en),
      .raddr (rd_addr),
      .rdata (rd_data)
   );

   assign hs_mode                = hs_reg;
   assign chirp_drive            = chirp_reg;
   assign suspend                = susp_reg;
   assign writes_locked          = lock_reg;
   assign pullup_resistor_pin_oe = conn_reg;
   assign srp_drive              = srp_reg;
   assign buf_full               = ptr_reg[AW];
   assign buf_words              = ptr_reg;
   assign rx_overrun             = ovr_reg;

   property p_fs_until_reset;
      @(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_FS) |=> (state_reg != ST_HS);
   endproperty
   a_fs_until_reset: assert property (p_fs_until_reset)
      else $error("left full speed without chirp");

   property p_hs_needs_ack;
      @(posedge clk) disable iff (!rst_int_n)
      $rose(hs_reg) |-> $past(ack) && $past(chirp_reg);
   endproperty
   a_hs_needs_ack: assert property (p_hs_needs_ack)
      else $error("high speed entered without host handshake");

   property p_idle_fallback;
      @(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_HS && !act && cnt_reg == CNT_W'(IDLE_CYC - 1))
         |=> !hs_reg && state_reg == ST_SE0_CHK;
   endproperty
   a_idle_fallback: assert property (p_idle_fallback)
      else $error("no fallback after high speed idle");

   property p_chirp_on_se0;
      @(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_SE0_CHK && se0 && se0_run_reg == RUN_W'(SE0_MIN_CYC - 1))
         |=> ##1 chirp_reg;
   endproperty
   a_chirp_on_se0: assert property (p_chirp_on_se0)
      else $error("qualifying se0 did not restart chirp");

   property p_window_suspend;
      @(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_SE0_CHK && !reset_seen && cnt_reg == CNT_W'(SE0_MAX_CYC - 1))
         |=> susp_reg && !hs_reg;
   endproperty
   a_window_suspend: assert property (p_window_suspend)
      else $error("no suspend after empty se0 window");

   property p_connect_write;
      @(posedge clk) disable iff (!rst_int_n)
      (fw_wr && !lock_reg && fw_sel == SEL_CONNECT)
         |=> pullup_resistor_pin_oe == $past(fw_wdata[CONNECT_BIT]);
   endproperty
   a_connect_write: assert property (p_connect_write)
      else $error("pull-up does not follow connect bit");

   property p_bus_reset_keeps;
      @(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_CHIRP && !fw_wr) |=> $stable(pullup_resistor_pin_oe);
   endproperty
   a_bus_reset_keeps: assert property (p_bus_reset_keeps)
      else $error("bus reset changed connect bit");

   property p_locked_ignored;
      @(posedge clk) disable iff (!rst_int_n)
      (lock_reg && fw_wr && fw_sel != UNLOCK_SEL) |=> $stable(pullup_resistor_pin_oe)
         && (ptr_reg >= $past(ptr_reg) || $past(ep_read_done || dma_drain_done));
   endproperty
   a_locked_ignored: assert property (p_locked_ignored)
      else $error("write acted while locked");

   property p_clear_empties;
      @(posedge clk) disable iff (!rst_int_n)
      (clr && !push) |=> buf_words == '0 ##1 !buf_full;
   endproperty
   a_clear_empties: assert property (p_clear_empties)
      else $error("buffer clear did not discard");

   property p_full_holds;
      @(posedge clk) disable iff (!rst_int_n)
      (buf_full && !release_buf) |=> buf_full;
   endproperty
   a_full_holds: assert property (p_full_holds)
      else $error("buffer released without consumer");
endmodule : usd_link
`default_nettype wire

/* File: hw/usd_pkg.sv */
// shared constants and types for the usb speed detect and connect block
package usd_pkg;
   localparam longint CLK_HZ     = 25_000_000;
   localparam longint IDLE_MS    = 3;
   localparam longint SE0_MIN_US = 100;
   localparam longint SE0_MAX_US = 875;
   localparam longint CHIRP_US   = 1000;
   localparam longint SRP_MS     = 5;

   localparam int IDLE_CYC_DEF    = int'(IDLE_MS * CLK_HZ / 1000);
   localparam int SE0_MIN_CYC     = int'((SE0_MIN_US * CLK_HZ + 999_999) / 1_000_000);
   localparam int SE0_MAX_CYC_DEF = int'(SE0_MAX_US * CLK_HZ / 1_000_000);
   localparam int CHIRP_CYC_DEF   = int'(CHIRP_US * CLK_HZ / 1_000_000);
   localparam int SRP_CYC_DEF     = int'(SRP_MS * CLK_HZ / 1000);

   localparam int CNT_W = 17;
   localparam int RUN_W = 12;

   localparam int WORD_W    = 16;
   localparam int RAM_BYTES = 8192;
   localparam int RAM_DEPTH = RAM_BYTES / (WORD_W / 8);
   localparam int AW        = $clog2(RAM_DEPTH);

   localparam logic [7:0] SYNC_MATCH = 8'h80;
   localparam logic [2:0] STUFF_RUN  = 3'h6;
   localparam logic [3:0] LAST_BIT   = 4'hF;

   localparam int PIN_SE0   = 0;
   localparam int PIN_ACT   = 1;
   localparam int PIN_ACK   = 2;
   localparam int PIN_LINE  = 3;
   localparam int PIN_STB   = 4;
   localparam int PIN_VBUS  = 5;
   localparam int PIN_COUNT = 6;

   localparam logic [1:0] SEL_CONNECT     = 2'h0;
   localparam logic [1:0] SEL_CLEAR       = 2'h1;
   localparam logic [1:0] SEL_SRP         = 2'h2;
   localparam logic [1:0] UNLOCK_SEL_DEF  = 2'h3;
   localparam logic [15:0] UNLOCK_CODE_DEF = 16'h5A3C;
   localparam int CONNECT_BIT = 0;
   localparam int CLEAR_BIT   = 0;
   localparam int SRP_BIT     = 0;

   typedef enum logic [2:0] {ST_FS, ST_CHIRP, ST_HS, ST_SE0_CHK, ST_SUSPEND} usd_state_t;
endpackage : usd_pkg

/* File: hw/usd_ram.sv */
// endpoint buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module usd_ram
   import usd_pkg::*;
#(
   parameter int W     = WORD_W,
   parameter int DEPTH = RAM_DEPTH,
   parameter int A     = AW
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         we,
   input  wire logic [A-1:0] waddr,
   input  wire logic [W-1:0] wdata,
   input  wire logic         re,
   input  wire logic [A-1:0] raddr,
   output logic      [W-1:0] rdata
);
   logic [W-1:0] mem [DEPTH];
   logic [W-1:0] rdata_reg;

   assign rdata = rdata_reg;

   // array itself carries no reset; contents are meaningless until written
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (re) begin
         rdata_reg <= mem[raddr];
      end
   end
endmodule : usd_ram
`default_nettype wire

/* File: hw/usd_skid.sv */
// two-entry buffer so a stall by the receiver loses no word
`timescale 1ns/10ps
`default_nettype none
module usd_skid
   import usd_pkg::*;
#(
   parameter int W = WORD_W
) (
   input wire logic     clk,
   input wire logic     rst_n,
   usd_stream_if.snk    in_s,
   usd_stream_if.src    out_s
);
   logic [W-1:0] mem_reg [2];
   logic [W-1:0] mem_next [2];
   logic [1:0]   cnt_reg, cnt_next;
   logic         rd_reg, rd_next;
   logic         wr_reg, wr_next;
   logic         push, pop;

   assign in_s.ready  = (cnt_reg != 2'h2);
   assign out_s.valid = (cnt_reg != 2'h0);
   assign out_s.data  = mem_reg[rd_reg];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   always_comb begin
      mem_next = mem_reg;
      rd_next  = rd_reg;
      wr_next  = wr_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_s.data;
         wr_next          = !wr_reg;
      end
      if (pop) begin
         rd_next = !rd_reg;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         cnt_reg    <= 2'h0;
         rd_reg     <= 1'b0;
         wr_reg     <= 1'b0;
      end else begin
         mem_reg <= mem_next;
         cnt_reg <= cnt_next;
         rd_reg  <= rd_next;
         wr_reg  <= wr_next;
      end
   end
endmodule : usd_skid
`default_nettype wire

/* File: hw/usd_stream_if.sv */
// valid/ready word stream between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface usd_stream_if #(parameter int W = 16) ();
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : usd_stream_if
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the usb link block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import usd_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n, fw_wr, ep_done, dma_done, rd_en;
   logic [1:0] fw_sel;
   logic [15:0] fw_wdata, w;
   logic [AW-1:0] rd_addr;
   logic se0, act, ack, line, stb, vbus;
   logic hs_mode, chirp_drive, suspend, writes_locked, oe, srp_drive, buf_full, rx_overrun;
   logic [AW:0] buf_words;
   logic [WORD_W-1:0] rd_data;
   logic [15:0] exp_q[$];
   int miscompares = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   usd_host host_i (.clk(clk), .se0(se0), .act(act), .ack(ack), .line(line), .stb(stb),
      .vbus(vbus));
   usd_link #(.IDLE_CYC(200), .SE0_MAX_CYC(3000), .CHIRP_CYC(100), .SRP_CYC(50)) usd_link_i (
      .clk(clk), .rst_n(rst_n), .bus_se0_pin(se0), .bus_activity_pin(act),
      .host_chirp_ack_pin(ack), .rx_line_pin(line), .rx_bit_stb_pin(stb),
      .vbus_present_pin(vbus), .fw_wr(fw_wr), .fw_sel(fw_sel), .fw_wdata(fw_wdata),
      .ep_read_done(ep_done), .dma_drain_done(dma_done), .rd_en(rd_en), .rd_addr(rd_addr),
      .hs_mode(hs_mode), .chirp_drive(chirp_drive), .suspend(suspend),
      .writes_locked(writes_locked), .pullup_resistor_pin_oe(oe), .srp_drive(srp_drive),
      .buf_full(buf_full), .buf_words(buf_words), .rd_data(rd_data), .rx_overrun(rx_overrun));
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_for(ref logic s, input logic v, input int n);
      for (int k = 0; k < n && s !== v; k++) begin
         @(posedge clk);
         #1;
      end
      if (s !== v) begin
         miscompares++;
         $display("FAIL %0t wait ran out", $time);
         test_done();
      end
   endtask : wait_for
   task automatic step();
      repeat (2) @(posedge clk);
      #1;
   endtask : step
   task automatic fw(input logic [1:0] s, input logic [15:0] d);
      logic [15:0] junk;
      junk = 16'($urandom());
      @(posedge clk);
      fw_wr <= 1'b1;
      fw_sel <= s;
      // only bit0 counts, except for the unlock word
      fw_wdata <= (s == UNLOCK_SEL_DEF) ? d : {junk[15:1], d[0]};
      @(posedge clk);
      fw_wr <= 1'b0;
      fw_sel <= junk[1:0];
      fw_wdata <= junk;
      step();
   endtask : fw
   task automatic pulse(input logic dma);
      @(posedge clk);
      ep_done <= !dma;
      dma_done <= dma;
      @(posedge clk);
      ep_done <= 1'b0;
      dma_done <= 1'b0;
      step();
   endtask : pulse
   // long reset, then the host must answer the chirp while se0 still stands
   task automatic hs_up();
      host_i.pins(1'b1, 1'b1, 1'b0);
      wait_for(chirp_drive, 1'b1, 2700);
      host_i.pins(1'b1, 1'b1, 1'b1);
      wait_for(hs_mode, 1'b1, 10);
      host_i.pins(1'b0, 1'b1, 1'b0);
   endtask : hs_up
   initial begin
      {rst_n, fw_wr, fw_sel, fw_wdata, ep_done, dma_done, rd_en, rd_addr} = '0;
      void'($urandom(32'h3414FE5A));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(oe, 1'b0);
      chk(hs_mode, 1'b0);
      fw(SEL_CONNECT, 16'h0001);
      chk(oe, 1'b1);
      fw(SEL_CONNECT, 16'h0000);
      chk(oe, 1'b0);
      fw(SEL_CONNECT, 16'h0001);
      hs_up();
      chk(hs_mode, 1'b1);
      chk(oe, 1'b1);
      host_i.pins(1'b0, 1'b0, 1'b0);
      repeat (150) @(posedge clk);
      #1;
      chk(hs_mode, 1'b1);
      wait_for(hs_mode, 1'b0, 150);
      hs_up();
      chk(hs_mode, 1'b1);
      host_i.pins(1'b0, 1'b0, 1'b0);
      wait_for(hs_mode, 1'b0, 300);
      wait_for(suspend, 1'b1, 3200);
      chk(chirp_drive, 1'b0);
      host_i.pins(1'b0, 1'b1, 1'b0);
      wait_for(writes_locked, 1'b1, 20);
      chk(suspend, 1'b0);
      fw(SEL_CONNECT, 16'h0000);
      chk(oe, 1'b1);
      fw(UNLOCK_SEL_DEF, UNLOCK_CODE_DEF);
      chk(writes_locked, 1'b0);
      for (int i = 0; i < 2; i++) begin
         w = (i == 0) ? 16'h00FE : 16'($urandom() & 32'hFFFE);
         exp_q.push_back(w);
         host_i.send_word(w);
         repeat (6) @(posedge clk);
         #1;
         chk(buf_words, 16'(i + 1));
         chk(buf_full, 1'b0);
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         rd_en <= 1'b1;
         rd_addr <= AW'(i);
         @(posedge clk);
         rd_en <= 1'b0;
         step();
         chk(rd_data, exp_q[i]);
      end
      pulse(1'b0);
      chk(buf_words, 16'h0000);
      host_i.send_word(16'h1234);
      repeat (6) @(posedge clk);
      pulse(1'b1);
      chk(buf_words, 16'h0000);
      host_i.send_word(16'hA5A4);
      repeat (6) @(posedge clk);
      fw(SEL_CLEAR, 16'h0001);
      chk(buf_words, 16'h0000);
      chk(rx_overrun, 1'b0);
      fw(SEL_CONNECT, 16'h0000);
      host_i.power(1'b0);
      // power loss needs the pin synchroniser to reach the logic first
      repeat (3) @(posedge clk);
      fw(SEL_SRP, 16'h0001);
      chk(srp_drive, 1'b1);
      repeat (60) @(posedge clk);
      #1;
      chk(srp_drive, 1'b0);
      test_done();
   end
endmodule : testbench
`default_nettype wire

/* File: verification/usd_host.sv */
// usb host model driving the bus-side pins of the link block
`timescale 1ns/10ps
`default_nettype none
module usd_host (
   input  wire logic clk,
   output var logic  se0,
   output var logic  act,
   output var logic  ack,
   output var logic  line,
   output var logic  stb,
   output var logic  vbus
);
   initial begin
      // idle: no se0, activity seen, no answer, strobe low, line at the receiver's reset level
      {se0, act, ack, line, stb, vbus} = 6'h11;
   end
   // levels change just after an edge and hold, as a real transceiver would
   task automatic pins(input logic s, input logic a, input logic k);
      @(posedge clk);
      se0 <= s;
      act <= a;
      ack <= k;
   endtask : pins
   task automatic power(input logic v);
      @(posedge clk);
      vbus <= v;
   endtask : power
   task automatic send_bit(input logic b);
      @(posedge clk);
      if (!b) line <= ~line;   // nrzi: a zero toggles the line
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
   endtask : send_bit
   // the receiver drops the bit after six ones, so a zero is inserted after every six ones
   task automatic send_word(input logic [15:0] w);
      int ones;
      ones = 0;
      for (int i = 0; i < 8; i++) send_bit(i == 7);
      for (int i = 0; i < 16; i++) begin
         send_bit(w[i]);
         ones = w[i] ? ones + 1 : 0;
         if (ones == 6) begin
            send_bit(1'b0);
            ones = 0;
         end
      end
      pins(1'b1, act, 1'b0);
      repeat (3) @(posedge clk);
      pins(1'b0, act, 1'b0);
   endtask : send_word
endmodule : usd_host
`default_nettype wire
